//--- bench/pmc_power_mode_control_monitor.sv
// Checker of the power-mode controller ports
`timescale 1ns/1ps
module pmc_power_mode_control_monitor #(
  parameter RESET_WAKE_CYC = 20,
  parameter SLEEP_TICK_CYC = 4
) (
  input wire        sys_clk,
  input wire        rst_n,
  input wire [15:0] regAddr,
  input wire [7:0]  regWdata,
  input wire        regWrite,
  input wire        regRead,
  input wire [7:0]  regRdata,
  input wire        extIrq,
  input wire        wakeIrq,
  input wire        idleExitIrq,
  input wire        analogRegOn,
  input wire        digitalRegOn,
  input wire        mainOscOn,
  input wire        sleepTimerOn,
  input wire        cpuClkEn,
  input wire        periphClkEn,
  input wire        cpuResumeIrq
);
  reg  [15:0] bootCnt_q;
  reg  [15:0] oscCnt_q;
  wire [3:0]  pwr = {analogRegOn, digitalRegOn, mainOscOn, sleepTimerOn};
  wire        ctlWr = regWrite && regAddr == 16'h0087;
  // Cycles since reset, and cycles of running oscillator with core stopped
  always @(posedge sys_clk) begin
    bootCnt_q <= !rst_n ? 16'h0000 : bootCnt_q + {15'h0000, ~&bootCnt_q};
    oscCnt_q  <= !rst_n || cpuClkEn || !mainOscOn ? 16'h0000 : oscCnt_q + 16'h0001;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_power_sets: assert property (pwr inside {4'hF, 4'h5, 4'h1, 4'h0})
    else $error("illegal power set");
  chk_run_normal: assert property (cpuClkEn |-> pwr == 4'hF)
    else $error("core runs without full power");
  chk_halt_stops: assert property (
    ctlWr && regWdata[1] ##1 !wakeIrq |-> ##1 !cpuClkEn && !periphClkEn)
    else $error("halt left a clock running");
  chk_idle_split: assert property (
    ctlWr && regWdata[1:0] == 2'b01 && cpuClkEn ##1 !idleExitIrq |-> ##1 !cpuClkEn && periphClkEn)
    else $error("idle clock split wrong");
  chk_idle_exit: assert property (
    idleExitIrq && periphClkEn && !cpuClkEn && !ctlWr |-> ##[1:2] cpuClkEn)
    else $error("idle not left");
  chk_resume_pulse: assert property (cpuResumeIrq |=> !cpuResumeIrq)
    else $error("resume pulse too long");
  chk_ext_release: assert property (cpuResumeIrq |-> !$past(extIrq))
    else $error("resumed with interrupt held");
  // Assumes a settle value of at least 0x11
  chk_settle_min: assert property (cpuResumeIrq |-> oscCnt_q >= 17 * SLEEP_TICK_CYC)
    else $error("settle delay too short");
  chk_boot_wait: assert property (cpuClkEn |-> bootCnt_q >= RESET_WAKE_CYC)
    else $error("core started too early");
  cov_resume: cover property (cpuResumeIrq);
  cov_idle: cover property (periphClkEn && !cpuClkEn);
  cov_deep: cover property (pwr == 4'h0);
endmodule // pmc_power_mode_control_monitor

bind pmc_power_mode_control pmc_power_mode_control_monitor #(
  .RESET_WAKE_CYC(RESET_WAKE_CYC), .SLEEP_TICK_CYC(SLEEP_TICK_CYC)) i_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .extIrq(extIrq),
  .wakeIrq(wakeIrq), .idleExitIrq(idleExitIrq), .analogRegOn(analogRegOn),
  .digitalRegOn(digitalRegOn), .mainOscOn(mainOscOn), .sleepTimerOn(sleepTimerOn),
  .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .cpuResumeIrq(cpuResumeIrq));

//--- bench/pmc_power_mode_control_tb.sv
// Self-checking bench of the power-mode controller
`timescale 1ns/1ps
`include "pmc_map.vh"
module pmc_power_mode_control_tb;
  localparam RWC = 20;
  localparam STC = 4;
  reg         sys_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [15:0] regAddr = 16'h0000;
  reg  [7:0]  regWdata = 8'h00;
  reg         regWrite = 1'b0;
  reg         regRead = 1'b0;
  reg         extGo = 1'b0;
  reg  [15:0] extLen = 16'h0000;
  reg         wakeGo = 1'b0;
  reg         idleGo = 1'b0;
  wire [7:0]  regRdata;
  wire        extIrq, wakeIrq, idleExitIrq, cpuClkEn, periphClkEn, cpuResumeIrq;
  wire        analogRegOn, digitalRegOn, mainOscOn, sleepTimerOn;
  wire [7:0]  pwr = {4'h0, analogRegOn, digitalRegOn, mainOscOn, sleepTimerOn};
  wire [7:0]  clk = {6'h00, cpuClkEn, periphClkEn};
  integer     errors = 0;
  integer     cmpCount = 0;
  integer     cycCnt = 0;
  integer     lvl, t, lo;

  always #25 sys_clk = ~sys_clk;

  pmc_power_mode_control #(.RESET_WAKE_CYC(RWC), .SLEEP_TICK_CYC(STC)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .extIrq(extIrq),
    .wakeIrq(wakeIrq), .idleExitIrq(idleExitIrq), .analogRegOn(analogRegOn),
    .digitalRegOn(digitalRegOn), .mainOscOn(mainOscOn), .sleepTimerOn(sleepTimerOn),
    .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .cpuResumeIrq(cpuResumeIrq));
  pmc_wake_src i_src (.sys_clk(sys_clk), .extGo(extGo), .extLen(extLen), .wakeGo(wakeGo),
    .idleGo(idleGo), .extIrq(extIrq), .wakeIrq(wakeIrq), .idleExitIrq(idleExitIrq));

  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  task ck(input [63:0] nm, input [7:0] exp, input [7:0] got);
    begin
      cmpCount = cmpCount + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task cyc(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask

  task wr(input [15:0] a, input [7:0] d);
    begin
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      // Strobe drops on the sampling edge, clear of the next call
      @(posedge sys_clk);
      regWrite <= 1'b0;
      #1;
    end
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input [15:0] a, input [7:0] exp);
    begin
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1;
      ck("rdata", exp, regRdata);
    end
  endtask

  task kick(input integer w);
    begin
      if (w == 0) idleGo <= 1'b1;
      else wakeGo <= 1'b1;
      cyc(1);
      idleGo <= 1'b0;
      wakeGo <= 1'b0;
      cyc(3);
    end
  endtask

  task boot;
    begin
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(RWC - 2);
      ck("bootclk", 8'h00, clk);
      ck("bootpwr", 8'h0F, pwr);
      cyc(6);
      ck("runclk", 8'h03, clk);
      $display("test boot done");
    end
  endtask

  always @(posedge sys_clk) begin
    cycCnt = cycCnt + 1;
    if (cycCnt == 3000) begin
      errors = errors + 1;
      final_report;
    end
  end

  initial begin
    boot;
    rd(`PMC_ADDR_POWER_CTRL, `PMC_POWER_CTRL_RST);
    rd(`PMC_ADDR_SETTLE, `PMC_SETTLE_RST);
    rd(16'h1234, 8'h00);
    wr(`PMC_ADDR_SETTLE, 8'h11);
    wr(`PMC_ADDR_SLEEP_INT, 8'h03);
    rd(`PMC_ADDR_SLEEP_INT, 8'h03);
    wr(`PMC_ADDR_PD_CTRL, 8'h02);
    rd(`PMC_ADDR_PD_CTRL, 8'h02);
    $display("test registers done");
    wr(`PMC_ADDR_POWER_CTRL, 8'h01);
    cyc(2);
    ck("idleclk", 8'h01, clk);
    kick(0);
    ck("runclk", 8'h03, clk);
    wr(`PMC_ADDR_POWER_CTRL, 8'h03);
    cyc(2);
    ck("haltclk", 8'h00, clk);
    kick(1);
    rd(`PMC_ADDR_POWER_CTRL, 8'h01);
    ck("idleclk", 8'h01, clk);
    kick(0);
    rd(`PMC_ADDR_POWER_CTRL, 8'h00);
    $display("test halt idle done");
    for (lvl = 1; lvl < 4; lvl = lvl + 1) begin
      wr(`PMC_ADDR_PD_CTRL, 8'h80 | lvl[7:0]);
      wr(`PMC_ADDR_POWER_CTRL, 8'h02);
      cyc(3);
      ck("downpwr", lvl == 1 ? 8'h05 : lvl == 2 ? 8'h01 : 8'h00, pwr);
      ck("downclk", 8'h00, clk);
      lo = lvl == 1 ? 19 * STC : lvl == 2 ? 17 * STC : 150;
      extLen <= lvl == 2 ? 16'h000A : 16'h0096;
      extGo <= lvl != 1;
      cyc(1);
      extGo <= 1'b0;
      for (t = 1; cpuResumeIrq !== 1'b1 && t < 600; t = t + 1) cyc(1);
      ck("resume", 8'h01, {7'h00, t >= lo && t <= lo + 16});
      ck("runpwr", 8'h0F, pwr);
      ck("runclk", 8'h03, clk);
      cyc(1);
      rd(`PMC_ADDR_POWER_CTRL, 8'h00);
      rd(`PMC_ADDR_STATUS, lvl == 1 ? 8'h09 : 8'h11);
      $display("test power-down level %0d done", lvl);
    end
    wr(`PMC_ADDR_PD_CTRL, 8'h83);
    wr(`PMC_ADDR_POWER_CTRL, 8'h02);
    cyc(3);
    ck("downpwr", 8'h00, pwr);
    boot;
    final_report;
  end
endmodule // pmc_power_mode_control_tb

//--- bench/pmc_wake_src.sv
// Wake-source model: external interrupt line and core interrupt pulses
`timescale 1ns/1ps
module pmc_wake_src (
  input  wire        sys_clk,
  input  wire        extGo,
  input  wire [15:0] extLen,
  input  wire        wakeGo,
  input  wire        idleGo,
  output reg         extIrq,
  output reg         wakeIrq,
  output reg         idleExitIrq
);
  reg [15:0] extCnt_q = 16'h0000;
  initial {extIrq, wakeIrq, idleExitIrq} = 3'h0;
  // Line released early or late as the scenario asks
  always @(posedge sys_clk) begin
    extCnt_q    <= extGo ? extLen : extCnt_q - {15'h0000, |extCnt_q};
    extIrq      <= extGo || extCnt_q > 16'h0001;
    wakeIrq     <= wakeGo;
    idleExitIrq <= idleGo;
  end
endmodule // pmc_wake_src

//--- rtl/pmc_delay_timer.v
// Loadable down-counter that reports when a delay has run out
`timescale 1ns/1ps
module pmc_delay_timer #(
  parameter WIDTH = 8
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire             load,
  input  wire [WIDTH-1:0] loadValue,
  input  wire             tick,
  output wire             done
);
  reg [WIDTH-1:0] count_q;
  reg             busy_q;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      count_q <= {WIDTH{1'b0}};
      busy_q  <= 1'b0;
    end else if (load) begin
      count_q <= loadValue;
      busy_q  <= 1'b1;
    end else if (busy_q && tick) begin
      if (count_q == {WIDTH{1'b0}}) begin
        busy_q <= 1'b0;
      end else begin
        count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  assign done = !busy_q && !load;
endmodule // pmc_delay_timer

//--- rtl/pmc_map.vh
// Address map, field positions, reset values and timing counts of the power-mode controller
//
// Overview of operation
// - External-interrupt wake resumes only after settle delay and interrupt release.
// - Normal: all on; level one: digital regulator and sleep timer on only.
// - Level two: only sleep timer on; level three: everything off.
// - Sleep-timer wake waits the programmed settle delay before the core runs.
// - Core-halt bit set stops every processor clock.
// - Enabled wake interrupt ends core halt; service routine then next instruction.
// - Idle bit set stops processor clocks, peripheral clocks keep running.
// - Non-timer, non-external interrupt clears idle bit and leaves idle.
// - Two-bit level field selects mode; writing go bit arms it, then setting core-halt bit begins it.
// - Hardware reset wakes from any level, about 1001 microseconds to resume.
// - Sleep interval register sets power-down duration ending on sleep-timer wake.
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

`define PMC_ADDR_POWER_CTRL   16'h0087
`define PMC_ADDR_PD_CTRL      16'h22F1
`define PMC_ADDR_SETTLE       16'h22F4
`define PMC_ADDR_SLEEP_INT    16'h22F5
`define PMC_ADDR_STATUS       16'h22F6

`define PMC_IDLE_BIT          0
`define PMC_HALT_BIT          1
`define PMC_LEVEL_LSB         0
`define PMC_LEVEL_MSB         1
`define PMC_GO_BIT            7

`define PMC_POWER_CTRL_RST    8'h00
`define PMC_PD_CTRL_RST       8'h00
`define PMC_SETTLE_RST        8'h11
`define PMC_SLEEP_INT_RST     8'h01

`define PMC_CLK_MHZ           20
`define PMC_RESET_WAKE_NS     1001000
`define PMC_RESET_WAKE_CYC    ((`PMC_RESET_WAKE_NS * `PMC_CLK_MHZ) / 1000)
`define PMC_SLEEP_TICK_CYC    610

`endif

//--- rtl/pmc_power_mode_control.v
// Power-mode controller: chip power-down levels, wake sequencing and core halt / idle
`timescale 1ns/1ps
`include "pmc_map.vh"
module pmc_power_mode_control #(
  parameter RESET_WAKE_CYC = `PMC_RESET_WAKE_CYC,
  parameter SLEEP_TICK_CYC = `PMC_SLEEP_TICK_CYC
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire [15:0] regAddr,
  input  wire [7:0]  regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRdata,
  input  wire        extIrq,
  input  wire        wakeIrq,
  input  wire        idleExitIrq,
  output reg         analogRegOn,
  output reg         digitalRegOn,
  output reg         mainOscOn,
  output reg         sleepTimerOn,
  output reg         cpuClkEn,
  output reg         periphClkEn,
  output reg         cpuResumeIrq
);
  localparam [2:0] ST_BOOT   = 3'h0;
  localparam [2:0] ST_RUN    = 3'h1;
  localparam [2:0] ST_DOWN   = 3'h2;
  localparam [2:0] ST_SETTLE = 3'h3;

  localparam [1:0] SRC_NONE  = 2'h0;
  localparam [1:0] SRC_SLEEP = 2'h1;
  localparam [1:0] SRC_EXT   = 2'h2;
  localparam [1:0] SRC_RESET = 2'h3;

  localparam [1:0] LVL_NORMAL = 2'h0;
  localparam [1:0] LVL_THREE  = 2'h3;

  localparam integer RESET_WAKE_LAST = RESET_WAKE_CYC - 1;
  localparam integer SLEEP_TICK_END  = SLEEP_TICK_CYC - 1;
  localparam [14:0]  RESET_WAKE_LOAD = RESET_WAKE_LAST[14:0];
  localparam [9:0]   SLEEP_TICK_LAST = SLEEP_TICK_END[9:0];
  localparam [7:0]   POWER_CTRL_RST  = `PMC_POWER_CTRL_RST;
  localparam [7:0]   PD_CTRL_RST     = `PMC_PD_CTRL_RST;

  // Domain enables {analog reg, digital reg, main osc, sleep timer} per level
  function [3:0] levelPower;
    input [1:0] level;
    begin
      case (level)
        2'h0:    levelPower = 4'hF;
        2'h1:    levelPower = 4'h5;
        2'h2:    levelPower = 4'h1;
        2'h3:    levelPower = 4'h0;
        default: levelPower = 4'hF;
      endcase
    end
  endfunction

  function isAddr;
    input [15:0] addr;
    input [15:0] target;
    begin
      isAddr = (addr == target);
    end
  endfunction

  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [1:0] wakeSrc_q;
  reg        haltBit_q;
  reg        idleBit_q;
  reg  [1:0] level_q;
  reg        goArmed_q;
  reg  [7:0] settleDelay_q;
  reg  [7:0] sleepInterval_q;
  reg  [7:0] sleepCount_q;
  reg  [9:0] tickDiv_q;
  wire       sleepTick;
  wire       settleDone;
  wire       bootDone;
  wire       wrPowerCtrl;
  wire       wrPdCtrl;
  wire       enterDown;
  wire       sleepExpired;
  wire       extWakeDown;
  wire       settleLoad;
  wire       settleExit;
  wire [3:0] powerNow;
  wire       haltHold;
  reg        bootStart_q;

  assign wrPowerCtrl = regWrite && isAddr(regAddr, `PMC_ADDR_POWER_CTRL);
  assign wrPdCtrl    = regWrite && isAddr(regAddr, `PMC_ADDR_PD_CTRL);

  // Sleep oscillator rate, one pulse per tick
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      tickDiv_q <= 10'h000;
    end else if (tickDiv_q == SLEEP_TICK_LAST) begin
      tickDiv_q <= 10'h000;
    end else begin
      tickDiv_q <= tickDiv_q + 10'h001;
    end
  end
  assign sleepTick = (tickDiv_q == SLEEP_TICK_LAST);

  assign enterDown    = (state_q == ST_RUN) && goArmed_q && haltBit_q;
  assign sleepExpired = (state_q == ST_DOWN) && (level_q != LVL_THREE) && sleepTick
                        && (sleepCount_q >= sleepInterval_q - 8'h01);
  assign extWakeDown  = (state_q == ST_DOWN) && extIrq;
  assign settleLoad   = extWakeDown || (sleepExpired && !extIrq);
  // External wake also waits for the interrupt line to be released
  assign settleExit   = (state_q == ST_SETTLE) && settleDone
                        && !((wakeSrc_q == SRC_EXT) && extIrq);

  pmc_delay_timer #(
    .WIDTH (8)
  ) uSettle (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .load      (settleLoad),
    .loadValue (settleDelay_q),
    .tick      (sleepTick),
    .done      (settleDone)
  );

  pmc_delay_timer #(
    .WIDTH (15)
  ) uResetWake (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .load      (bootStart_q),
    .loadValue (RESET_WAKE_LOAD),
    .tick      (1'b1),
    .done      (bootDone)
  );

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      bootStart_q <= 1'b1;
    end else begin
      bootStart_q <= 1'b0;
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_BOOT: begin
        if (bootDone && !bootStart_q) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (enterDown) begin
          state_d = ST_DOWN;
        end
      end
      ST_DOWN: begin
        if (settleLoad) begin
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settleExit) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_BOOT;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q   <= ST_BOOT;
      wakeSrc_q <= SRC_RESET;
    end else begin
      state_q <= state_d;
      if (extWakeDown) begin
        wakeSrc_q <= SRC_EXT;
      end else if (sleepExpired) begin
        wakeSrc_q <= SRC_SLEEP;
      end else if (enterDown) begin
        wakeSrc_q <= SRC_NONE;
      end
    end
  end

  // Sleep interval count in power-down while the sleep timer is powered
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sleepCount_q <= 8'h00;
    end else if (state_q != ST_DOWN) begin
      sleepCount_q <= 8'h00;
    end else if (sleepTick && (level_q != LVL_THREE)) begin
      sleepCount_q <= sleepCount_q + 8'h01;
    end
  end

  // Control registers; a software set beats a same-cycle hardware clear
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      haltBit_q       <= POWER_CTRL_RST[`PMC_HALT_BIT];
      idleBit_q       <= POWER_CTRL_RST[`PMC_IDLE_BIT];
      level_q         <= PD_CTRL_RST[`PMC_LEVEL_MSB:`PMC_LEVEL_LSB];
      goArmed_q       <= 1'b0;
      settleDelay_q   <= `PMC_SETTLE_RST;
      sleepInterval_q <= `PMC_SLEEP_INT_RST;
    end else begin
      if (wrPowerCtrl && regWdata[`PMC_HALT_BIT]) begin
        haltBit_q <= 1'b1;
      end else if (wrPowerCtrl) begin
        haltBit_q <= 1'b0;
      end else if (settleExit || ((state_q == ST_RUN) && !goArmed_q && wakeIrq)) begin
        haltBit_q <= 1'b0;
      end
      if (wrPowerCtrl && regWdata[`PMC_IDLE_BIT]) begin
        idleBit_q <= 1'b1;
      end else if (wrPowerCtrl || idleExitIrq) begin
        idleBit_q <= 1'b0;
      end
      if (wrPdCtrl) begin
        level_q   <= regWdata[`PMC_LEVEL_MSB:`PMC_LEVEL_LSB];
        goArmed_q <= regWdata[`PMC_GO_BIT]
                     && (regWdata[`PMC_LEVEL_MSB:`PMC_LEVEL_LSB] != LVL_NORMAL);
      end else if (enterDown) begin
        goArmed_q <= 1'b0;
      end
      if (regWrite && isAddr(regAddr, `PMC_ADDR_SETTLE)) begin
        settleDelay_q <= regWdata;
      end
      if (regWrite && isAddr(regAddr, `PMC_ADDR_SLEEP_INT)) begin
        sleepInterval_q <= regWdata;
      end
    end
  end

  assign powerNow = (state_q == ST_DOWN) ? levelPower(level_q) : levelPower(LVL_NORMAL);

  // Halt ends on the wake exit edge, so clocks return beside the resume pulse
  assign haltHold = haltBit_q && !settleExit;

  // Registered enables change only on the clock edge, so gated clocks never glitch
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      analogRegOn  <= 1'b1;
      digitalRegOn <= 1'b1;
      mainOscOn    <= 1'b1;
      sleepTimerOn <= 1'b1;
      cpuClkEn     <= 1'b0;
      periphClkEn  <= 1'b0;
      cpuResumeIrq <= 1'b0;
    end else begin
      analogRegOn  <= powerNow[3];
      digitalRegOn <= powerNow[2];
      mainOscOn    <= powerNow[1];
      sleepTimerOn <= powerNow[0];
      cpuClkEn     <= (state_d == ST_RUN) && !haltHold && !idleBit_q;
      periphClkEn  <= (state_d == ST_RUN) && !haltHold;
      cpuResumeIrq <= settleExit;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (!regRead) begin
      regRdata <= 8'h00;
    end else begin
      case (regAddr)
        `PMC_ADDR_POWER_CTRL: regRdata <= {6'h00, haltBit_q, idleBit_q};
        `PMC_ADDR_PD_CTRL:    regRdata <= {6'h00, level_q};
        `PMC_ADDR_SETTLE:     regRdata <= settleDelay_q;
        `PMC_ADDR_SLEEP_INT:  regRdata <= sleepInterval_q;
        `PMC_ADDR_STATUS:     regRdata <= {2'h0, goArmed_q, wakeSrc_q, state_q};
        default:              regRdata <= 8'h00;
      endcase
    end
  end
endmodule // pmc_power_mode_control
